// file: src/dpm_pkg.sv
package dpm_pkg;

   localparam int unsigned ADDR_W    = 3;
   localparam int unsigned DATA_W    = 5;
   localparam int unsigned NUM_REGS  = 5;
   localparam int unsigned CNT_W     = 4;

   localparam logic [2:0] ADDR_MODE   = 3'h0;
   localparam logic [2:0] ADDR_MULT   = 3'h1;
   localparam logic [2:0] ADDR_DIV1   = 3'h2;
   localparam logic [2:0] ADDR_DIV2   = 3'h3;
   localparam logic [2:0] ADDR_OUTEN  = 3'h4;

   localparam logic [4:0] REG_RESET   = 5'h00;
   localparam logic [4:0] DIV2_FRAC   = 5'h1f;

   localparam int unsigned BIT_PLL_EN   = 0;
   localparam int unsigned MODE_LSB     = 1;
   localparam int unsigned MODE_MSB     = 4;
   localparam int unsigned OE_FRAME     = 4;
   localparam int unsigned OE_FIRST     = 3;
   localparam int unsigned OE_SECOND    = 2;
   localparam int unsigned LOCK_MSB     = 1;
   localparam int unsigned LOCK_LSB     = 0;

   localparam logic [3:0] MODE_REV_56   = 4'h3;
   localparam logic [3:0] MODE_REV_64   = 4'h7;
   localparam logic [3:0] MODE_E1_T1    = 4'h8;
   localparam logic [3:0] MODE_FR_56_TE = 4'h9;
   localparam logic [3:0] MODE_FR_56_TT = 4'ha;
   localparam logic [3:0] MODE_FR_64_ET = 4'hb;
   localparam logic [3:0] MODE_FR_64_EE = 4'hc;

   localparam logic [1:0] LOCK_BOTH  = 2'h0;
   localparam logic [1:0] LOCK_PLL2  = 2'h1;
   localparam logic [1:0] LOCK_PLL1  = 2'h2;
   localparam logic [1:0] LOCK_OFF   = 2'h3;

   localparam logic [3:0] HDR_BITS   = 4'h4;
   localparam logic [3:0] FRAME_BITS = 4'h9;
   localparam logic [3:0] CNT_OVER   = 4'ha;

   typedef enum logic [1:0] {
      CLASS_UNSUPPORTED,
      CLASS_REVERSE,
      CLASS_FRACTIONAL,
      CLASS_E1_TO_T1
   } dpm_class_type;

   typedef enum logic [1:0] {
      REF_NONE,
      REF_56K,
      REF_64K,
      REF_E1
   } dpm_ref_type;

   typedef enum logic [1:0] {
      FREQ_NONE,
      FREQ_T1,
      FREQ_E1
   } dpm_freq_type;

endpackage : dpm_pkg

// file: src/dpm_serial.sv
`timescale 1ns/100ps
`default_nettype none

module dpm_serial (
   input  wire logic                        clk_i,
   input  wire logic                        reset_n_i,
   input  wire logic                        cs_n_i,
   input  wire logic                        sclk_i,
   input  wire logic                        sdi_i,
   output logic                             sdo_o,
   output logic                             sdo_oe_o,
   output logic                             wr_stb_o,
   output logic [dpm_pkg::ADDR_W-1:0]       wr_addr_o,
   output logic [dpm_pkg::DATA_W-1:0]       wr_data_o,
   output logic [dpm_pkg::ADDR_W-1:0]       rd_addr_o,
   input  wire logic [dpm_pkg::DATA_W-1:0]  rd_data_i
);

   logic                        sclk_reg;
   logic                        cs_n_reg;
   logic [8:0]                  shift_reg;
   logic [dpm_pkg::CNT_W-1:0]   cnt_reg;
   logic                        rd_reg;
   logic [dpm_pkg::DATA_W-1:0]  rd_sh_reg;
   logic                        rise;
   logic                        fall;
   logic                        frame_end;

   assign rise      = sclk_i & ~sclk_reg & ~cs_n_i;
   assign fall      = ~sclk_i & sclk_reg & ~cs_n_i;
   assign frame_end = cs_n_i & ~cs_n_reg;
   // address is complete on the fourth rising edge, with the last bit still on the pin
   assign rd_addr_o = {shift_reg[1:0], sdi_i};

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         sclk_reg <= 1'b0;
         cs_n_reg <= 1'b1;
      end
      else
      begin
         sclk_reg <= sclk_i;
         cs_n_reg <= cs_n_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         shift_reg <= '0;
         cnt_reg   <= '0;
      end
      else if (cs_n_i)
         cnt_reg <= '0;
      else if (rise)
      begin
         shift_reg <= {shift_reg[7:0], sdi_i};
         // saturate so an overlong frame is never taken as a write
         if (cnt_reg != dpm_pkg::CNT_OVER)
            cnt_reg <= cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         rd_reg    <= 1'b0;
         rd_sh_reg <= '0;
         sdo_o     <= 1'b0;
         sdo_oe_o  <= 1'b0;
      end
      else if (cs_n_i)
      begin
         rd_reg   <= 1'b0;
         sdo_oe_o <= 1'b0;
      end
      else if (rise && cnt_reg == dpm_pkg::HDR_BITS - 4'h1)
      begin
         rd_reg    <= shift_reg[2];
         rd_sh_reg <= rd_data_i;
      end
      else if (fall && rd_reg)
      begin
         sdo_o     <= rd_sh_reg[dpm_pkg::DATA_W-1];
         sdo_oe_o  <= 1'b1;
         rd_sh_reg <= {rd_sh_reg[dpm_pkg::DATA_W-2:0], 1'b0};
      end
   end

   // the write lands only when the frame closes, never mid-shift
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         wr_stb_o  <= 1'b0;
         wr_addr_o <= '0;
         wr_data_o <= '0;
      end
      else
      begin
         wr_stb_o  <= frame_end && cnt_reg == dpm_pkg::FRAME_BITS && !shift_reg[8];
         wr_addr_o <= shift_reg[7:5];
         wr_data_o <= shift_reg[4:0];
      end
   end

   a_no_drive_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      cs_n_i |=> !sdo_oe_o)
      else $error("serial output driven outside a frame");

endmodule : dpm_serial

`default_nettype wire

// file: src/dpm_top.sv
`timescale 1ns/100ps
`default_nettype none

module dpm_top (
   input  wire logic                     clk_i,
   input  wire logic                     reset_n_i,
   input  wire logic                     master_strap_i,
   input  wire logic                     ser_cs_n_i,
   input  wire logic                     ser_clk_i,
   input  wire logic                     ser_data_i,
   input  wire logic                     pll1_lock_i,
   input  wire logic                     pll2_lock_i,
   output logic                          ser_data_o,
   output logic                          ser_data_oe_o,
   output dpm_pkg::dpm_class_type        mode_class_o,
   output dpm_pkg::dpm_ref_type          ref_base_o,
   output dpm_pkg::dpm_freq_type         pll1_freq_o,
   output dpm_pkg::dpm_freq_type         pll2_freq_o,
   output logic [dpm_pkg::DATA_W-1:0]    ref_multiple_o,
   output logic                          mode_ok_o,
   output logic                          pll1_run_o,
   output logic                          pll2_run_o,
   output logic                          first_output_enable_o,
   output logic                          second_output_enable_o,
   output logic                          frame_pulse_enable_o,
   output logic                          lock_indicator_o
);

   logic                          wr_stb;
   logic [dpm_pkg::ADDR_W-1:0]    wr_addr;
   logic [dpm_pkg::DATA_W-1:0]    wr_data;
   logic [dpm_pkg::ADDR_W-1:0]    rd_addr;
   logic [dpm_pkg::DATA_W-1:0]    rd_data;
   logic [dpm_pkg::DATA_W-1:0]    cfg_reg [dpm_pkg::NUM_REGS];
   logic [3:0]                    mode_code;
   dpm_pkg::dpm_class_type        class_next;
   dpm_pkg::dpm_ref_type          ref_next;
   dpm_pkg::dpm_freq_type         f1_next;
   dpm_pkg::dpm_freq_type         f2_next;
   logic [dpm_pkg::DATA_W-1:0]    multiple_next;
   logic                          ok_next;
   logic                          lock_next;

   function automatic logic reg_hit(input logic [dpm_pkg::ADDR_W-1:0] a,
                                    input logic [dpm_pkg::ADDR_W-1:0] idx);
      reg_hit = (a == idx);
   endfunction : reg_hit

   dpm_serial u_serial (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .cs_n_i    (ser_cs_n_i),
      .sclk_i    (ser_clk_i),
      .sdi_i     (ser_data_i),
      .sdo_o     (ser_data_o),
      .sdo_oe_o  (ser_data_oe_o),
      .wr_stb_o  (wr_stb),
      .wr_addr_o (wr_addr),
      .wr_data_o (wr_data),
      .rd_addr_o (rd_addr),
      .rd_data_i (rd_data)
   );

   genvar gi;
   generate
      for (gi = 0; gi < dpm_pkg::NUM_REGS; gi++)
      begin : g_cfg
         always_ff @(posedge clk_i)
         begin
            if (!reset_n_i)
               cfg_reg[gi] <= dpm_pkg::REG_RESET;
            else if (wr_stb && reg_hit(wr_addr, 3'(gi)))
               cfg_reg[gi] <= wr_data;
         end
      end
   endgenerate

   // unmapped addresses read back as zero
   always_comb
   begin
      rd_data = '0;
      for (int i = 0; i < dpm_pkg::NUM_REGS; i++)
      begin
         if (reg_hit(rd_addr, 3'(i)))
            rd_data = cfg_reg[i];
      end
   end

   assign mode_code = cfg_reg[dpm_pkg::ADDR_MODE][dpm_pkg::MODE_MSB:dpm_pkg::MODE_LSB];

   always_comb
   begin
      class_next = dpm_pkg::CLASS_UNSUPPORTED;
      ref_next   = dpm_pkg::REF_NONE;
      f1_next    = dpm_pkg::FREQ_NONE;
      f2_next    = dpm_pkg::FREQ_NONE;
      case (mode_code)
         dpm_pkg::MODE_REV_56, dpm_pkg::MODE_REV_64:
         begin
            class_next = dpm_pkg::CLASS_REVERSE;
            ref_next   = (mode_code == dpm_pkg::MODE_REV_56) ? dpm_pkg::REF_56K : dpm_pkg::REF_64K;
            f1_next    = dpm_pkg::FREQ_T1;
            f2_next    = dpm_pkg::FREQ_E1;
         end
         dpm_pkg::MODE_FR_56_TE:
         begin
            class_next = dpm_pkg::CLASS_FRACTIONAL;
            ref_next   = dpm_pkg::REF_56K;
            f1_next    = dpm_pkg::FREQ_T1;
            f2_next    = dpm_pkg::FREQ_E1;
         end
         dpm_pkg::MODE_FR_56_TT:
         begin
            class_next = dpm_pkg::CLASS_FRACTIONAL;
            ref_next   = dpm_pkg::REF_56K;
            f1_next    = dpm_pkg::FREQ_T1;
            f2_next    = dpm_pkg::FREQ_T1;
         end
         dpm_pkg::MODE_FR_64_ET:
         begin
            class_next = dpm_pkg::CLASS_FRACTIONAL;
            ref_next   = dpm_pkg::REF_64K;
            f1_next    = dpm_pkg::FREQ_E1;
            f2_next    = dpm_pkg::FREQ_T1;
         end
         dpm_pkg::MODE_FR_64_EE:
         begin
            class_next = dpm_pkg::CLASS_FRACTIONAL;
            ref_next   = dpm_pkg::REF_64K;
            f1_next    = dpm_pkg::FREQ_E1;
            f2_next    = dpm_pkg::FREQ_E1;
         end
         dpm_pkg::MODE_E1_T1:
         begin
            class_next = dpm_pkg::CLASS_E1_TO_T1;
            ref_next   = dpm_pkg::REF_E1;
            f1_next    = dpm_pkg::FREQ_T1;
            f2_next    = dpm_pkg::FREQ_T1;
         end
         default:
         begin
            class_next = dpm_pkg::CLASS_UNSUPPORTED;
         end
      endcase
   end

   // the multiplier field is only consulted in E1-to-T1 mode
   always_comb
   begin
      multiple_next = '0;
      case (class_next)
         dpm_pkg::CLASS_FRACTIONAL:
            multiple_next = cfg_reg[dpm_pkg::ADDR_DIV1];
         dpm_pkg::CLASS_E1_TO_T1:
            multiple_next = {1'b0, cfg_reg[dpm_pkg::ADDR_MULT][dpm_pkg::MODE_MSB:dpm_pkg::MODE_LSB]};
         default:
            multiple_next = '0;
      endcase
   end

   // a slave strap is out of scope for these modes, so the PLLs stay parked
   assign ok_next = master_strap_i && class_next != dpm_pkg::CLASS_UNSUPPORTED;

   always_comb
   begin
      lock_next = 1'b0;
      case (cfg_reg[dpm_pkg::ADDR_OUTEN][dpm_pkg::LOCK_MSB:dpm_pkg::LOCK_LSB])
         dpm_pkg::LOCK_BOTH: lock_next = pll1_lock_i & pll2_lock_i;
         dpm_pkg::LOCK_PLL2: lock_next = pll2_lock_i;
         dpm_pkg::LOCK_PLL1: lock_next = pll1_lock_i;
         dpm_pkg::LOCK_OFF:  lock_next = 1'b0;
         default:            lock_next = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         mode_class_o   <= dpm_pkg::CLASS_UNSUPPORTED;
         ref_base_o     <= dpm_pkg::REF_NONE;
         pll1_freq_o    <= dpm_pkg::FREQ_NONE;
         pll2_freq_o    <= dpm_pkg::FREQ_NONE;
         ref_multiple_o <= '0;
         mode_ok_o      <= 1'b0;
      end
      else
      begin
         mode_class_o   <= class_next;
         ref_base_o     <= ref_next;
         pll1_freq_o    <= f1_next;
         pll2_freq_o    <= f2_next;
         ref_multiple_o <= multiple_next;
         mode_ok_o      <= ok_next;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         pll1_run_o             <= 1'b0;
         pll2_run_o             <= 1'b0;
         first_output_enable_o  <= 1'b0;
         second_output_enable_o <= 1'b0;
         frame_pulse_enable_o   <= 1'b0;
         lock_indicator_o       <= 1'b0;
      end
      else
      begin
         pll1_run_o             <= ok_next && cfg_reg[dpm_pkg::ADDR_MODE][dpm_pkg::BIT_PLL_EN];
         pll2_run_o             <= ok_next && cfg_reg[dpm_pkg::ADDR_MULT][dpm_pkg::BIT_PLL_EN];
         first_output_enable_o  <= ok_next && cfg_reg[dpm_pkg::ADDR_MODE][dpm_pkg::BIT_PLL_EN]
                                   && cfg_reg[dpm_pkg::ADDR_OUTEN][dpm_pkg::OE_FIRST];
         second_output_enable_o <= ok_next && cfg_reg[dpm_pkg::ADDR_MULT][dpm_pkg::BIT_PLL_EN]
                                   && cfg_reg[dpm_pkg::ADDR_OUTEN][dpm_pkg::OE_SECOND];
         frame_pulse_enable_o   <= cfg_reg[dpm_pkg::ADDR_OUTEN][dpm_pkg::OE_FRAME];
         lock_indicator_o       <= lock_next;
      end
   end

   // checker copies of the write address and data from the previous cycle, taken every cycle
   logic [dpm_pkg::ADDR_W-1:0]    wr_addr_seen_reg;
   logic [dpm_pkg::DATA_W-1:0]    wr_data_seen_reg;
   always_ff @(posedge clk_i)
   begin
      wr_addr_seen_reg <= wr_addr;
      wr_data_seen_reg <= wr_data;
   end

   // unmapped addresses have no register to land in
   a_write_lands: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      wr_stb |=> (wr_addr_seen_reg >= 3'(dpm_pkg::NUM_REGS)) || cfg_reg[wr_addr_seen_reg] == wr_data_seen_reg)
      else $error("register write did not land");

   a_reverse_freqs: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (mode_code == dpm_pkg::MODE_REV_64) |=>
      (mode_class_o == dpm_pkg::CLASS_REVERSE && ref_base_o == dpm_pkg::REF_64K
       && pll1_freq_o == dpm_pkg::FREQ_T1 && pll2_freq_o == dpm_pkg::FREQ_E1))
      else $error("reverse mode outputs wrong");

   a_frac_freqs: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (mode_code == dpm_pkg::MODE_FR_64_ET) |=>
      (ref_base_o == dpm_pkg::REF_64K && pll1_freq_o == dpm_pkg::FREQ_E1 && pll2_freq_o == dpm_pkg::FREQ_T1))
      else $error("fractional mode outputs wrong");

   a_pll1_run: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      pll1_run_o |-> $past(cfg_reg[dpm_pkg::ADDR_MODE][dpm_pkg::BIT_PLL_EN]) && $past(master_strap_i))
      else $error("first PLL runs without enable");

   a_pll2_run: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (ok_next && cfg_reg[dpm_pkg::ADDR_MULT][dpm_pkg::BIT_PLL_EN]) |=> pll2_run_o)
      else $error("second PLL not started");

   a_reverse_ignore: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (class_next == dpm_pkg::CLASS_REVERSE) |=> ref_multiple_o == 5'h00)
      else $error("reverse mode used divider contents");

   a_frac_multiple: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (class_next == dpm_pkg::CLASS_FRACTIONAL) |=> ref_multiple_o == $past(cfg_reg[dpm_pkg::ADDR_DIV1]))
      else $error("fractional multiple wrong");

   a_e1_multiple: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (mode_code == dpm_pkg::MODE_E1_T1) |=>
      (mode_class_o == dpm_pkg::CLASS_E1_TO_T1 && pll2_freq_o == dpm_pkg::FREQ_T1
       && ref_multiple_o[3:0] == $past(cfg_reg[dpm_pkg::ADDR_MULT][dpm_pkg::MODE_MSB:dpm_pkg::MODE_LSB])))
      else $error("E1 to T1 setup wrong");

   a_lock_forced: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (cfg_reg[dpm_pkg::ADDR_OUTEN][dpm_pkg::LOCK_MSB:dpm_pkg::LOCK_LSB] == dpm_pkg::LOCK_OFF)[*2] |-> !lock_indicator_o)
      else $error("lock output not forced low");

   a_lock_first: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (cfg_reg[dpm_pkg::ADDR_OUTEN][dpm_pkg::LOCK_MSB:dpm_pkg::LOCK_LSB] == dpm_pkg::LOCK_PLL1)
      |=> lock_indicator_o == $past(pll1_lock_i))
      else $error("lock output does not follow first PLL");

   a_frame_enable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      frame_pulse_enable_o == $past(cfg_reg[dpm_pkg::ADDR_OUTEN][dpm_pkg::OE_FRAME])
      && (!first_output_enable_o || pll1_run_o))
      else $error("output enables wrong");

   c_reverse: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      mode_class_o == dpm_pkg::CLASS_REVERSE && first_output_enable_o);
   c_fractional: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      mode_class_o == dpm_pkg::CLASS_FRACTIONAL && second_output_enable_o);
   c_e1_to_t1: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      mode_class_o == dpm_pkg::CLASS_E1_TO_T1 && mode_ok_o);
   c_readback: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      ser_data_oe_o && ser_data_o);

endmodule : dpm_top

`default_nettype wire

// file: tb/dpm_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module dpm_host_model (
   input  wire logic clk_i,
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      data_o,
   input  wire logic data_i,
   input  wire logic oe_i
);
   // each serial level held four cycles, twice what the port needs, to absorb the sampling lag
   localparam int unsigned HALF = 4;

   initial
   begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      data_o = 1'b0;
   end

   task automatic bit_out(input logic b);
      data_o <= b;
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b0;
      repeat (HALF) @(posedge clk_i);
   endtask : bit_out

   // shifts the top nbits of word, msb first; read bits are taken late in each low phase
   task automatic frame(input logic [8:0] word, input int nbits, output logic [4:0] rd);
      rd = 5'h00;
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      for (int i = 0; i < nbits; i++)
      begin
         bit_out(word[8-i]);
         if (i >= 3 && i <= 7)
         begin
            // an undriven line reads as the inverse, so a missing enable never passes
            rd = {rd[3:0], oe_i ? data_i : ~data_i};
         end
      end
      cs_n_o <= 1'b1;
      // released line must not keep showing the last bit
      data_o <= ~data_o;
      repeat (6) @(posedge clk_i);
   endtask : frame
endmodule : dpm_host_model

`default_nettype wire

// file: tb/tb_dual_pll_mode_config.sv
`timescale 1ns/100ps
`default_nettype none

module tb_dual_pll_mode_config;
   logic                   clk_i;
   logic                   reset_n_i;
   logic                   master_strap_i;
   logic                   pll1_lock_i;
   logic                   pll2_lock_i;
   logic                   ser_cs_n;
   logic                   ser_clk;
   logic                   ser_din;
   logic                   ser_dout;
   logic                   ser_oe;
   dpm_pkg::dpm_class_type mode_class_o;
   dpm_pkg::dpm_ref_type   ref_base_o;
   dpm_pkg::dpm_freq_type  pll1_freq_o;
   dpm_pkg::dpm_freq_type  pll2_freq_o;
   logic [4:0]             ref_multiple_o;
   logic                   mode_ok_o;
   logic                   pll1_run_o;
   logic                   pll2_run_o;
   logic                   first_oe;
   logic                   second_oe;
   logic                   frame_oe;
   logic                   lock_o;
   int                     miscompares;
   int                     n_checks;

   dpm_top dpm_top_i (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .master_strap_i(master_strap_i),
      .ser_cs_n_i(ser_cs_n), .ser_clk_i(ser_clk), .ser_data_i(ser_din),
      .pll1_lock_i(pll1_lock_i), .pll2_lock_i(pll2_lock_i),
      .ser_data_o(ser_dout), .ser_data_oe_o(ser_oe), .mode_class_o(mode_class_o),
      .ref_base_o(ref_base_o), .pll1_freq_o(pll1_freq_o), .pll2_freq_o(pll2_freq_o),
      .ref_multiple_o(ref_multiple_o), .mode_ok_o(mode_ok_o), .pll1_run_o(pll1_run_o),
      .pll2_run_o(pll2_run_o), .first_output_enable_o(first_oe),
      .second_output_enable_o(second_oe), .frame_pulse_enable_o(frame_oe),
      .lock_indicator_o(lock_o));

   dpm_host_model dpm_host_model_i (
      .clk_i(clk_i), .cs_n_o(ser_cs_n), .sclk_o(ser_clk), .data_o(ser_din), .data_i(ser_dout),
      .oe_i(ser_oe));

   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic results();
      if (miscompares == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   task automatic wr(input logic [2:0] a, input logic [4:0] d);
      logic [4:0] r;
      dpm_host_model_i.frame({1'b0, a, d}, 9, r);
   endtask : wr

   task automatic rd_chk(input logic [2:0] a, input logic [4:0] exp);
      logic [4:0] r;
      dpm_host_model_i.frame({1'b1, a, 5'h00}, 8, r);
      check("read", r, exp);
      check("oe", 5'(ser_oe), 5'h00);
   endtask : rd_chk

   task automatic chk_mode(input logic [1:0] c, input logic [1:0] rb, input logic [1:0] f1,
                           input logic [1:0] f2, input logic [4:0] m, input logic [2:0] ok_runs);
      check("class", 5'(mode_class_o), 5'(c));
      check("ref", 5'(ref_base_o), 5'(rb));
      check("f1", 5'(pll1_freq_o), 5'(f1));
      check("f2", 5'(pll2_freq_o), 5'(f2));
      check("mult", ref_multiple_o, m);
      check("okrun", 5'({mode_ok_o, pll1_run_o, pll2_run_o}), 5'(ok_runs));
   endtask : chk_mode

   task automatic t_reset();
      for (int a = 0; a < 6; a++)
      begin
         rd_chk(3'(a), 5'h00);
      end
      chk_mode(dpm_pkg::CLASS_UNSUPPORTED, dpm_pkg::REF_NONE, dpm_pkg::FREQ_NONE, dpm_pkg::FREQ_NONE,
               5'h00, 3'h0);
   endtask : t_reset

   task automatic t_reverse();
      logic [3:0] code;
      for (int k = 0; k < 2; k++)
      begin
         code = k ? dpm_pkg::MODE_REV_64 : dpm_pkg::MODE_REV_56;
         wr(3'h0, {code, 1'b1});
         wr(3'h1, 5'h1f);
         wr(3'h2, 5'h15);
         wr(3'h3, 5'h0a);
         wr(3'h4, 5'h1c);
         chk_mode(dpm_pkg::CLASS_REVERSE, k ? dpm_pkg::REF_64K : dpm_pkg::REF_56K, dpm_pkg::FREQ_T1,
                  dpm_pkg::FREQ_E1, 5'h00, 3'h7);
         check("oes", 5'({frame_oe, first_oe, second_oe}), 5'h07);
         rd_chk(3'h2, 5'h15);
         rd_chk(3'h0, {code, 1'b1});
      end
   endtask : t_reverse

   task automatic t_frac();
      logic [3:0] codes [4] = '{4'h9, 4'ha, 4'hb, 4'hc};
      logic [1:0] f1s [4] = '{dpm_pkg::FREQ_T1, dpm_pkg::FREQ_T1, dpm_pkg::FREQ_E1, dpm_pkg::FREQ_E1};
      logic [1:0] f2s [4] = '{dpm_pkg::FREQ_E1, dpm_pkg::FREQ_T1, dpm_pkg::FREQ_T1, dpm_pkg::FREQ_E1};
      for (int i = 0; i < 4; i++)
      begin
         wr(3'h0, {codes[i], 1'b1});
         wr(3'h1, 5'h15);
         wr(3'h2, 5'h1f - 5'(i));
         wr(3'h3, 5'h1f);
         chk_mode(dpm_pkg::CLASS_FRACTIONAL, i < 2 ? dpm_pkg::REF_56K : dpm_pkg::REF_64K, f1s[i], f2s[i],
                  5'h1f - 5'(i), 3'h7);
      end
   endtask : t_frac

   task automatic t_e1();
      wr(3'h0, {dpm_pkg::MODE_E1_T1, 1'b0});
      wr(3'h1, 5'h1e);
      wr(3'h2, 5'h1f);
      chk_mode(dpm_pkg::CLASS_E1_TO_T1, dpm_pkg::REF_E1, dpm_pkg::FREQ_T1, dpm_pkg::FREQ_T1,
               5'h0f, 3'h4);
      check("oes", 5'({first_oe, second_oe}), 5'h00);
      wr(3'h0, {dpm_pkg::MODE_E1_T1, 1'b1});
      wr(3'h1, 5'h01);
      chk_mode(dpm_pkg::CLASS_E1_TO_T1, dpm_pkg::REF_E1, dpm_pkg::FREQ_T1, dpm_pkg::FREQ_T1,
               5'h00, 3'h7);
      check("oes", 5'({first_oe, second_oe}), 5'h03);
   endtask : t_e1

   task automatic t_strap();
      master_strap_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      check("okrun", 5'({mode_ok_o, pll1_run_o, pll2_run_o, first_oe}), 5'h00);
      master_strap_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      check("okrun", 5'({mode_ok_o, pll1_run_o, pll2_run_o, first_oe}), 5'h0f);
   endtask : t_strap

   // select codes 00 both, 01 second only, 10 first only
   task automatic t_lock();
      logic exp;
      for (int s = 0; s < 3; s++)
      begin
         wr(3'h4, {3'b000, 2'(s)});
         check("frame", 5'(frame_oe), 5'h00);
         for (int v = 0; v < 4; v++)
         begin
            pll1_lock_i <= v[0];
            pll2_lock_i <= v[1];
            repeat (3) @(posedge clk_i);
            exp = (s == 2) ? v[0] : ((s == 1) ? v[1] : (v[0] & v[1]));
            check("lock", 5'(lock_o), 5'(exp));
         end
      end
      wr(3'h4, {3'b100, dpm_pkg::LOCK_OFF});
      check("lock", 5'({frame_oe, lock_o}), 5'h02);
   endtask : t_lock

   task automatic t_refused();
      logic [4:0] r;
      wr(3'h0, {dpm_pkg::MODE_REV_56, 1'b1});
      dpm_host_model_i.frame({4'h0, 4'hd, 1'b1}, 8, r);
      check("class", 5'(mode_class_o), 5'(dpm_pkg::CLASS_REVERSE));
      wr(3'h5, 5'h1f);
      rd_chk(3'h5, 5'h00);
      wr(3'h0, {4'hd, 1'b1});
      check("okrun", 5'({mode_class_o, mode_ok_o, pll1_run_o}), 5'h00);
   endtask : t_refused

   initial
   begin
      miscompares = 0;
      n_checks = 0;
      reset_n_i = 1'b0;
      master_strap_i = 1'b1;
      pll1_lock_i = 1'b0;
      pll2_lock_i = 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_reverse();
      t_frac();
      t_e1();
      t_strap();
      t_lock();
      t_refused();
      results();
   end

   // about 50 frames of roughly 110 cycles each fit well inside this span
   initial
   begin
      repeat (60000) @(posedge clk_i);
      miscompares++;
      results();
   end
endmodule : tb_dual_pll_mode_config

`default_nettype wire
